// ### hdl/tta_pkg.sv
// Package: register map, field positions, timing and carrier types
package tta_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] TTA_MASK_TWO_OFS = 8'h75;
  localparam logic [7:0] TTA_CFG_THREE_OFS = 8'h78;
  localparam logic [7:0] TTA_TIMER_OFS = 8'h79;
  localparam logic [7:0] TTA_LIMIT_OFS = 8'h7A;
  localparam logic [7:0] TTA_CFG_FOUR_OFS = 8'h7D;
  localparam logic [7:0] TTA_STATUS_TWO_OFS = 8'h42;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] TTA_REG_RST = 8'h00;
  localparam int TTA_CFG3_ALERT_BIT = 0;
  localparam int TTA_CFG3_THR_EN_BIT = 1;
  localparam int TTA_CFG3_FULL_SPEED_ON_THROTTLE_BIT = 2;
  localparam int TTA_CFG4_ALERT_B_BIT = 0;
  localparam int TTA_STAT_THR_BIT = 5;
  localparam logic [7:0] TTA_USED_BITS = 8'hFE;
  localparam logic [7:0] TTA_TIMER_FULL = 8'hFF;
  localparam logic [7:0] TTA_VIEW_SPLIT = 8'h02;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int TTA_CLK_KHZ = 25000;
  localparam int TTA_LSB_US = 22760;
  localparam int TTA_LSB_CYC = TTA_LSB_US * TTA_CLK_KHZ / 1000;
  localparam int TTA_DEB_CYC = 4;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tta_reg_req_t;

  typedef struct packed {
    logic diode_two;
    logic diode_one;
    logic fan_four;
    logic fan_three;
    logic fan_two;
    logic fan_one;
    logic overtemp;
  } tta_fault_t;

endpackage

// ### hdl/tta_throttle_sync.sv
// Link-clock side: synchroniser and debouncer of the throttle pin
`timescale 1ns/100ps
`default_nettype none
module tta_throttle_sync (
  input wire logic link_clk,
  input wire logic reset_n,
  input wire logic thermal_throttle_pin_n,
  output logic throttle_level
);

  // ---------------------------------------------------------------
  // Reset release in the link domain
  // ---------------------------------------------------------------
  logic lrst_meta_q;
  logic lrst_n_q;

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      lrst_meta_q <= 1'h0;
      lrst_n_q <= 1'h0;
    end else begin
      lrst_meta_q <= 1'h1;
      lrst_n_q <= lrst_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Pin synchroniser, asserted level is high internally
  // ---------------------------------------------------------------
  logic pin_meta_q;
  logic pin_sync_q;

  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      pin_meta_q <= 1'h0;
      pin_sync_q <= 1'h0;
    end else begin
      pin_meta_q <= ~thermal_throttle_pin_n;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Debounce: a new level must hold for a few link cycles
  // ---------------------------------------------------------------
  logic [2:0] deb_cnt_q;

  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      deb_cnt_q <= 3'h0;
      throttle_level <= 1'h0;
    end else if (pin_sync_q == throttle_level) begin
      deb_cnt_q <= 3'h0;
    end else if (deb_cnt_q == 3'(tta_pkg::TTA_DEB_CYC - 1)) begin
      deb_cnt_q <= 3'h0;
      throttle_level <= pin_sync_q;
    end else begin
      deb_cnt_q <= deb_cnt_q + 3'h1;
    end
  end

endmodule
`default_nettype wire

// ### hdl/tta_thermal_throttle_timer_alert.sv
// Throttle assertion timer, limit status and alert pin logic
`timescale 1ns/100ps
`default_nettype none
module tta_thermal_throttle_timer_alert #(
  parameter int LSB_CYCLES = tta_pkg::TTA_LSB_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic thermal_throttle_pin_n,
  input wire tta_pkg::tta_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire tta_pkg::tta_fault_t fault,
  input wire logic [2:0] fan_running,
  output logic [2:0] fan_force_full,
  output logic alert_a_out,
  output logic alert_a_oe,
  output logic alert_b_out,
  output logic alert_b_oe
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'h0;
      rst_n_q <= 1'h0;
    end else begin
      rst_meta_q <= 1'h1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Throttle pin: link-side conditioning, then level crossing
  // ---------------------------------------------------------------
  logic link_level;
  logic thr_meta_q;
  logic thr_lvl_q;

  tta_throttle_sync i_tta_throttle_sync (
    .link_clk(link_clk),
    .reset_n(reset_n),
    .thermal_throttle_pin_n(thermal_throttle_pin_n),
    .throttle_level(link_level)
  );

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      thr_meta_q <= 1'h0;
      thr_lvl_q <= 1'h0;
    end else begin
      thr_meta_q <= link_level;
      thr_lvl_q <= thr_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  logic [7:0] alert_mask_two_q;
  logic [7:0] config_three_q;
  logic [7:0] throttle_time_limit_q;
  logic [7:0] config_four_q;
  logic rd_timer;
  logic rd_status;
  logic thr_en;
  logic thr_act;

  assign rd_timer = reg_req.rd && (reg_req.addr == tta_pkg::TTA_TIMER_OFS);
  assign rd_status = reg_req.rd &&
                     (reg_req.addr == tta_pkg::TTA_STATUS_TWO_OFS);
  assign thr_en = config_three_q[tta_pkg::TTA_CFG3_THR_EN_BIT];
  // Monitoring only while the pin is given the throttle function
  assign thr_act = thr_en && thr_lvl_q;

  // ---------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      alert_mask_two_q <= tta_pkg::TTA_REG_RST;
      config_three_q <= tta_pkg::TTA_REG_RST;
      throttle_time_limit_q <= tta_pkg::TTA_REG_RST;
      config_four_q <= tta_pkg::TTA_REG_RST;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        tta_pkg::TTA_MASK_TWO_OFS: begin
          alert_mask_two_q <= reg_req.wdata & tta_pkg::TTA_USED_BITS;
        end
        tta_pkg::TTA_CFG_THREE_OFS: begin
          config_three_q <= reg_req.wdata;
        end
        tta_pkg::TTA_LIMIT_OFS: begin
          throttle_time_limit_q <= reg_req.wdata;
        end
        tta_pkg::TTA_CFG_FOUR_OFS: begin
          config_four_q <= reg_req.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Assertion timer
  // ---------------------------------------------------------------
  logic [19:0] sub_cnt_q;
  logic [7:0] units_q;
  logic seen_q;
  logic unit_done;
  logic [7:0] timer_now;

  // Below two units only the first-assertion flag shows
  function automatic logic [7:0] timer_view(input logic [7:0] units,
                                            input logic seen);
    if (units >= tta_pkg::TTA_VIEW_SPLIT) begin
      timer_view = units;
    end else begin
      timer_view = {7'h0, seen};
    end
  endfunction

  assign unit_done = (sub_cnt_q == 20'(LSB_CYCLES - 1));
  assign timer_now = timer_view(units_q, seen_q);

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sub_cnt_q <= 20'h0;
    end else if (rd_timer) begin
      sub_cnt_q <= 20'h0;
    end else if (thr_act) begin
      if (unit_done) begin
        sub_cnt_q <= 20'h0;
      end else begin
        sub_cnt_q <= sub_cnt_q + 20'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      units_q <= 8'h0;
    end else if (rd_timer) begin
      units_q <= 8'h0;
    end else if (thr_act && unit_done &&
                 (units_q != tta_pkg::TTA_TIMER_FULL)) begin
      units_q <= units_q + 8'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      seen_q <= 1'h0;
    end else if (rd_timer) begin
      seen_q <= thr_act;
    end else if (thr_act) begin
      seen_q <= 1'h1;
    end
  end

  // ---------------------------------------------------------------
  // Limit comparison and sticky status two
  // ---------------------------------------------------------------
  logic over_limit;
  logic [7:0] cond;
  logic [7:0] status_two_q;

  // Zero limit trips on the first assertion, one past two units
  assign over_limit = thr_en && (timer_now > throttle_time_limit_q);
  // Bit 5 reports the limit while the pin has the throttle function
  assign cond = {fault.diode_two, fault.diode_one,
                 thr_en ? over_limit : fault.fan_four,
                 fault.fan_three, fault.fan_two, fault.fan_one,
                 fault.overtemp, 1'h0};

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      status_two_q <= 8'h0;
    end else if (rd_status) begin
      // Set wins over the clear of the same cycle
      status_two_q <= cond;
    end else begin
      status_two_q <= status_two_q | cond;
    end
  end

  // ---------------------------------------------------------------
  // Alert pins, open drain, driven low while active
  // ---------------------------------------------------------------
  logic alert_any;

  assign alert_any = |(status_two_q & ~alert_mask_two_q &
                       tta_pkg::TTA_USED_BITS);
  assign alert_a_out = 1'h0;
  assign alert_b_out = 1'h0;

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      alert_a_oe <= 1'h0;
      alert_b_oe <= 1'h0;
    end else begin
      alert_a_oe <= alert_any &&
                    config_three_q[tta_pkg::TTA_CFG3_ALERT_BIT];
      alert_b_oe <= alert_any &&
                    config_four_q[tta_pkg::TTA_CFG4_ALERT_B_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Full duty override
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fan_force_full <= 3'h0;
    end else if (thr_act &&
                 config_three_q[tta_pkg::TTA_CFG3_FULL_SPEED_ON_THROTTLE_BIT]) begin
      fan_force_full <= fan_running;
    end else begin
      fan_force_full <= 3'h0;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata <= 8'h0;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        tta_pkg::TTA_MASK_TWO_OFS: reg_rdata <= alert_mask_two_q;
        tta_pkg::TTA_CFG_THREE_OFS: reg_rdata <= config_three_q;
        tta_pkg::TTA_TIMER_OFS: reg_rdata <= timer_now;
        tta_pkg::TTA_LIMIT_OFS: reg_rdata <= throttle_time_limit_q;
        tta_pkg::TTA_CFG_FOUR_OFS: reg_rdata <= config_four_q;
        tta_pkg::TTA_STATUS_TWO_OFS: reg_rdata <= status_two_q;
        default: reg_rdata <= 8'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_alert_a_gate: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    !config_three_q[tta_pkg::TTA_CFG3_ALERT_BIT] |=> !alert_a_oe)
    else $error("alert pin A driven while disabled");

  chk_alert_b_drive: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (alert_any && config_four_q[tta_pkg::TTA_CFG4_ALERT_B_BIT]) |=>
      alert_b_oe)
    else $error("alert pin B not driven");

  chk_mask_blocks: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    ((status_two_q & ~alert_mask_two_q & tta_pkg::TTA_USED_BITS) == 8'h0) |=>
      (!alert_a_oe && !alert_b_oe))
    else $error("masked source raised the alert");

  chk_limit_status: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    over_limit |=> status_two_q[tta_pkg::TTA_STAT_THR_BIT])
    else $error("limit exceeded without status");

  chk_status_sticky: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (status_two_q[tta_pkg::TTA_STAT_THR_BIT] && !rd_status) |=>
      status_two_q[tta_pkg::TTA_STAT_THR_BIT])
    else $error("status bit dropped without read");

  chk_timer_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (units_q == tta_pkg::TTA_TIMER_FULL && !rd_timer) |=>
      units_q == tta_pkg::TTA_TIMER_FULL)
    else $error("timer left full scale");

  chk_timer_pause: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (!thr_act && !rd_timer) |=> ($stable(units_q) && $stable(sub_cnt_q)))
    else $error("timer moved while negated");

  chk_read_restart: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (rd_timer && thr_act) |=> (timer_now == 8'h01 && units_q == 8'h0))
    else $error("read during assertion not restarted");

  chk_read_clear: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (rd_timer && !thr_act) |=> timer_now == 8'h00)
    else $error("timer not cleared by read");

  chk_first_assert: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (thr_act && !rd_timer && timer_now == 8'h00) |=> timer_now == 8'h01)
    else $error("first assertion not flagged");

  chk_zero_limit: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (rd_timer && thr_act && throttle_time_limit_q == 8'h00) |->
      ##2 status_two_q[tta_pkg::TTA_STAT_THR_BIT])
    else $error("zero limit status not set again");

  chk_full_speed_on_throttle_force: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (thr_act && config_three_q[tta_pkg::TTA_CFG3_FULL_SPEED_ON_THROTTLE_BIT]) |=>
      fan_force_full == $past(fan_running))
    else $error("running fans not forced to full");

  chk_full_speed_on_throttle_idle: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (!thr_act || !config_three_q[tta_pkg::TTA_CFG3_FULL_SPEED_ON_THROTTLE_BIT]) |=>
      fan_force_full == 3'h0)
    else $error("fans forced without full_speed_on_throttle");

endmodule
`default_nettype wire

// ### bench/tta_hot_src.sv
// Model of the CPU hot output that drives the throttle pin
`timescale 1ns/100ps
`default_nettype none
module tta_hot_src (
  input wire logic link_clk,
  input wire logic hold_low,
  input wire logic glitch,
  output logic pin_n
);
  logic g_q;
  logic [1:0] gcnt;

  initial begin
    pin_n = 1'b1;
    g_q = 1'b0;
    gcnt = 2'h0;
  end

  // Pin changes just after the source clock edge; a glitch lasts 2 cycles,
  // shorter than the debounce span
  always @(posedge link_clk) begin
    g_q <= glitch;
    if (glitch && !g_q) begin
      gcnt <= 2'h2;
    end else if (gcnt != 2'h0) begin
      gcnt <= gcnt - 2'h1;
    end
    pin_n <= ~(hold_low | (glitch & ~g_q) | (gcnt > 2'h1));
  end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking testbench of the throttle timer and alert block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int LSB = 32;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic pin_n;
  logic hold_low = 1'b0;
  logic glitch = 1'b0;
  tta_pkg::tta_reg_req_t req = '0;
  logic [7:0] reg_rdata;
  tta_pkg::tta_fault_t fault = '0;
  logic [2:0] fan_running = 3'h0;
  logic [2:0] fan_force_full;
  logic alert_a_out;
  logic alert_a_oe;
  logic alert_b_out;
  logic alert_b_oe;
  logic [7:0] exp_q[$];
  logic [1:0] rd_p = 2'h0;
  int fail_count = 0;
  int checks_done = 0;
  int seed = 32'hDD85;
  logic [7:0] m;
  logic [7:0] sb;

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #7;
    forever #32 link_clk = ~link_clk;
  end

  tta_thermal_throttle_timer_alert #(.LSB_CYCLES(LSB))
    i_tta_thermal_throttle_timer_alert (
    .sys_clk(sys_clk), .reset_n(reset_n), .link_clk(link_clk),
    .thermal_throttle_pin_n(pin_n), .reg_req(req), .reg_rdata(reg_rdata),
    .fault(fault), .fan_running(fan_running),
    .fan_force_full(fan_force_full), .alert_a_out(alert_a_out),
    .alert_a_oe(alert_a_oe), .alert_b_out(alert_b_out),
    .alert_b_oe(alert_b_oe)
  );

  tta_hot_src i_tta_hot_src (
    .link_clk(link_clk), .hold_low(hold_low), .glitch(glitch),
    .pin_n(pin_n)
  );

  // ---------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d of %0d checks", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Read data is taken on the falling edge one and a half cycles after the request is sampled
  always @(posedge sys_clk) begin
    rd_p <= {rd_p[0], req.rd};
  end
  always @(negedge sys_clk) begin
    if (rd_p[1]) begin
      check(reg_rdata, exp_q.pop_front());
    end
  end

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge sys_clk);
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    exp_q.push_back(e);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge sys_clk);
    req.rd = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic chk_alert(input logic ea, input logic eb);
    repeat (5) @(negedge sys_clk);
    check({6'h0, alert_a_oe, alert_b_oe}, {6'h0, ea, eb});
    // Open-drain data stays low, only the enables move
    check({6'h0, alert_a_out, alert_b_out}, 8'h00);
  endtask

  task automatic pulse(input int cyc);
    @(negedge sys_clk);
    hold_low = 1'b1;
    repeat (cyc) @(negedge sys_clk);
    hold_low = 1'b0;
    repeat (40) @(negedge sys_clk);
  endtask

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    final_report();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    rd(tta_pkg::TTA_MASK_TWO_OFS, 8'h00);
    rd(tta_pkg::TTA_CFG_THREE_OFS, 8'h00);
    rd(tta_pkg::TTA_TIMER_OFS, 8'h00);
    rd(tta_pkg::TTA_LIMIT_OFS, 8'h00);
    rd(tta_pkg::TTA_CFG_FOUR_OFS, 8'h00);
    rd(tta_pkg::TTA_STATUS_TWO_OFS, 8'h00);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    wr(tta_pkg::TTA_TIMER_OFS, 8'hFF);
    rd(tta_pkg::TTA_TIMER_OFS, 8'h00);
    m = $random(seed);
    wr(tta_pkg::TTA_MASK_TWO_OFS, m);
    rd(tta_pkg::TTA_MASK_TWO_OFS, m & tta_pkg::TTA_USED_BITS);
    wr(tta_pkg::TTA_MASK_TWO_OFS, 8'h00);
    // Alert pins stay off until enabled
    fault = 7'h01;
    chk_alert(1'b0, 1'b0);
    wr(tta_pkg::TTA_CFG_THREE_OFS, 8'h01);
    chk_alert(1'b1, 1'b0);
    wr(tta_pkg::TTA_CFG_FOUR_OFS, 8'h01);
    chk_alert(1'b1, 1'b1);
    // Every fault source, masked and unmasked
    for (int i = 0; i < 7; i++) begin
      sb = {7'h01 << i, 1'b0};
      fault = 7'h01 << i;
      chk_alert(1'b1, 1'b1);
      wr(tta_pkg::TTA_MASK_TWO_OFS, sb);
      chk_alert(1'b0, 1'b0);
      rd(tta_pkg::TTA_STATUS_TWO_OFS, sb);
      fault = '0;
      wr(tta_pkg::TTA_MASK_TWO_OFS, 8'h00);
      chk_alert(1'b1, 1'b1);
      rd(tta_pkg::TTA_STATUS_TWO_OFS, sb);
      rd(tta_pkg::TTA_STATUS_TWO_OFS, 8'h00);
      chk_alert(1'b0, 1'b0);
    end
    // Throttle timer against a limit of four units
    wr(tta_pkg::TTA_CFG_THREE_OFS, 8'h03);
    wr(tta_pkg::TTA_LIMIT_OFS, 8'h04);
    rd(tta_pkg::TTA_LIMIT_OFS, 8'h04);
    @(negedge sys_clk);
    glitch = 1'b1;
    repeat (40) @(negedge sys_clk);
    glitch = 1'b0;
    rd(tta_pkg::TTA_TIMER_OFS, 8'h00);
    pulse(20);
    rd(tta_pkg::TTA_TIMER_OFS, 8'h01);
    rd(tta_pkg::TTA_TIMER_OFS, 8'h00);
    repeat (3) pulse(LSB * 3 / 2);
    chk_alert(1'b0, 1'b0);
    rd(tta_pkg::TTA_STATUS_TWO_OFS, 8'h00);
    pulse(LSB * 3 / 2);
    chk_alert(1'b1, 1'b1);
    rd(tta_pkg::TTA_STATUS_TWO_OFS, 8'h20);
    rd(tta_pkg::TTA_TIMER_OFS, 8'h06);
    rd(tta_pkg::TTA_STATUS_TWO_OFS, 8'h20);
    rd(tta_pkg::TTA_STATUS_TWO_OFS, 8'h00);
    // Limit zero with the throttle alert masked
    wr(tta_pkg::TTA_LIMIT_OFS, 8'h00);
    wr(tta_pkg::TTA_MASK_TWO_OFS, 8'h20);
    pulse(20);
    chk_alert(1'b0, 1'b0);
    rd(tta_pkg::TTA_STATUS_TWO_OFS, 8'h20);
    // Full_speed_on_throttle, saturation and a read during assertion
    wr(tta_pkg::TTA_CFG_THREE_OFS, 8'h07);
    // At least one fan running and at least one stopped
    fan_running = 3'(1 + {$random(seed)} % 6);
    @(negedge sys_clk);
    hold_low = 1'b1;
    repeat (40) @(negedge sys_clk);
    check({5'h0, fan_force_full}, {5'h0, fan_running});
    repeat (LSB * 260) @(negedge sys_clk);
    rd(tta_pkg::TTA_TIMER_OFS, tta_pkg::TTA_TIMER_FULL);
    rd(tta_pkg::TTA_TIMER_OFS, 8'h01);
    rd(tta_pkg::TTA_STATUS_TWO_OFS, 8'h20);
    hold_low = 1'b0;
    repeat (40) @(negedge sys_clk);
    check({5'h0, fan_force_full}, 8'h00);
    repeat (10) @(negedge sys_clk);
    final_report();
  end
endmodule
`default_nettype wire
